/* hdl/vicp_pkg.sv */
// Notes on behaviour
// (RULE1) Port clock pin is input after reset; software may turn it to output.
// (RULE2) With input clock, sample all ten data lines on rising edge when valid.
// (RULE3) Never store data lines on edges where valid is low, except markers.
// (RULE4) Source holds valid high with data for the next rising port clock edge.
// (RULE5) Port clock and data rates up to 81 MHz are the documented ceiling; the synchronised pin takes rates well under the 20 MHz core clock.
// (RULE6) Optional message mode captures the two upper lines regardless of valid.
// (RULE7) Output clock is the core clock divided by a programmable integer.
// (RULE8) Lower eight lines carry 4:2:2 video or general high-speed data.
// (RULE9) Upper two lines extend the word to ten bits in raw ten-bit mode.
// (RULE10) In message mode line 8 marks message start and line 9 marks end.
// (RULE11) Captured words cross safely from the port clock into the core clock.
package vicp_pkg;
  localparam int ADDR_W = 12;
  localparam int WORD_W = 10;
  localparam int DIV_W = 8;
  // Register byte addresses.
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_DIV = 12'h004;
  localparam logic [11:0] ADDR_DATA = 12'h008;
  localparam logic [11:0] ADDR_MSG = 12'h00C;
  // Control register fields.
  localparam int CTRL_CLK_OUT = 0;
  localparam int CTRL_MSG_MODE = 1;
  localparam int CTRL_TEN_BIT = 2;
  localparam int CTRL_CAP_EN = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Data register fields.
  localparam int DATA_VALID_BIT = 16;
  localparam int DATA_OVERRUN_BIT = 17;
  // Message register fields.
  localparam int MSG_START_BIT = 0;
  localparam int MSG_END_BIT = 1;
  // Divider minimum and reset value.
  localparam logic [7:0] DIV_RESET = 8'h04;
  localparam logic [7:0] DIV_MIN = 8'h02;
  // Rates, kept for reference against the core clock.
  localparam int PORT_MAX_MHZ = 81;
  localparam int CORE_MHZ = 20;
endpackage

/* hdl/vicp_top.sv */
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module vicp_top #(
  parameter int WORD_W = 10,
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [vicp_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_port_clock_in,
  output logic capture_port_clock_out,
  output logic capture_port_clock_oe,
  input wire logic capture_data_valid,
  input wire logic [WORD_W-1:0] capture_data_lines
);
  import vicp_pkg::*;

  logic [3:0] ctrl, next_ctrl;
  logic [DIV_W-1:0] div, next_div;
  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic next_clk_out;
  logic next_pready, next_pslverr;
  logic [31:0] next_prdata;
  logic clk_s1, clk_s2, clk_s3;
  logic valid_s1, valid_s2;
  logic [WORD_W-1:0] data_s1, data_s2;
  logic [WORD_W-1:0] word, next_word;
  logic word_valid, next_word_valid;
  logic overrun, next_overrun;
  logic start_seen, next_start_seen;
  logic end_seen, next_end_seen;
  logic setup, access, wr_en, rd_data_clr, wr_msg;
  logic rise, sample;

  // APB strobes: the answer comes in the first access cycle.
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr_en = access && pwrite;
  assign rd_data_clr = access && !pwrite && (paddr == ADDR_DATA);
  assign wr_msg = wr_en && (paddr == ADDR_MSG);

  // Port clock edge, either from the pin or from our own divider.
  // The synchronised pin limits usable input rates to well under the core
  // rate; the 81 MHz ceiling applies only to a faster core clock.
  always_comb begin
    if (ctrl[CTRL_CLK_OUT]) begin
      rise = (div_cnt == '0); // RULE7
    end else begin
      rise = clk_s2 && !clk_s3; // RULE1 RULE5
    end
    sample = rise && ctrl[CTRL_CAP_EN] && valid_s2; // RULE2 RULE3 RULE4
  end

  // Register file and bus answer.
  always_comb begin
    next_ctrl = ctrl;
    next_div = div;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (wr_en && paddr == ADDR_CTRL) begin
      next_ctrl = pwdata[3:0]; // RULE1
    end else if (wr_en && paddr == ADDR_DIV) begin
      // A divisor below two cannot form a clock, so it is raised to two.
      if (pwdata[DIV_W-1:0] < DIV_MIN) begin
        next_div = DIV_W'(DIV_MIN);
      end else begin
        next_div = pwdata[DIV_W-1:0]; // RULE7
      end
    end
    if (setup) begin
      next_pready = 1'b1;
      next_prdata = 32'h0000_0000;
      if (paddr == ADDR_CTRL) begin
        next_prdata[3:0] = ctrl;
      end else if (paddr == ADDR_DIV) begin
        next_prdata[DIV_W-1:0] = div;
      end else if (paddr == ADDR_DATA) begin
        next_prdata[WORD_W-1:0] = word;
        next_prdata[DATA_VALID_BIT] = word_valid;
        next_prdata[DATA_OVERRUN_BIT] = overrun;
      end else if (paddr == ADDR_MSG) begin
        next_prdata[MSG_START_BIT] = start_seen;
        next_prdata[MSG_END_BIT] = end_seen;
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  // Register file state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      div <= DIV_W'(DIV_RESET);
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      div <= next_div;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // Divider and capture path; a new event beats a clear in the same cycle.
  always_comb begin
    next_div_cnt = '0;
    if (ctrl[CTRL_CLK_OUT] && div_cnt < div - 1'b1) begin
      next_div_cnt = div_cnt + 1'b1; // RULE7
    end
    next_clk_out = ctrl[CTRL_CLK_OUT] && (next_div_cnt < (div >> 1));
    next_word = word;
    next_word_valid = word_valid && !rd_data_clr;
    next_overrun = overrun && !rd_data_clr;
    next_start_seen = start_seen && !(wr_msg && pwdata[MSG_START_BIT]);
    next_end_seen = end_seen && !(wr_msg && pwdata[MSG_END_BIT]);
    if (sample) begin
      if (ctrl[CTRL_TEN_BIT]) begin
        next_word = data_s2; // RULE9
      end else begin
        next_word = {2'b00, data_s2[7:0]}; // RULE8
      end
      if (word_valid && !rd_data_clr) begin
        next_overrun = 1'b1;
      end
      next_word_valid = 1'b1; // RULE11
    end
    // Markers are caught on every rising edge in message mode with capture enabled, valid or not.
    if (rise && ctrl[CTRL_MSG_MODE] && ctrl[CTRL_CAP_EN]) begin
      if (data_s2[8]) begin
        next_start_seen = 1'b1; // RULE6 RULE10
      end
      if (data_s2[9]) begin
        next_end_seen = 1'b1; // RULE6 RULE10
      end
    end
  end

  // Synchronisers and capture state; pins pass two flip-flops first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      valid_s1 <= 1'b0;
      valid_s2 <= 1'b0;
      data_s1 <= '0;
      data_s2 <= '0;
      div_cnt <= '0;
      capture_port_clock_out <= 1'b0;
      capture_port_clock_oe <= 1'b0;
      word <= '0;
      word_valid <= 1'b0;
      overrun <= 1'b0;
      start_seen <= 1'b0;
      end_seen <= 1'b0;
    end else begin
      clk_s1 <= capture_port_clock_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      valid_s1 <= capture_data_valid;
      valid_s2 <= valid_s1;
      data_s1 <= capture_data_lines;
      data_s2 <= data_s1;
      div_cnt <= next_div_cnt;
      capture_port_clock_out <= next_clk_out;
      capture_port_clock_oe <= next_ctrl[CTRL_CLK_OUT]; // RULE1
      word <= next_word;
      word_valid <= next_word_valid;
      overrun <= next_overrun;
      start_seen <= next_start_seen;
      end_seen <= next_end_seen;
    end
  end

  sample_on_valid_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    sample |=> word_valid && word[7:0] == $past(data_s2[7:0]))
    else $error("Valid word was not stored.");

  ignore_invalid_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    (rise && !valid_s2) |=> word == $past(word))
    else $error("Word changed on an edge without valid.");

  msg_start_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    (rise && ctrl[CTRL_MSG_MODE] && ctrl[CTRL_CAP_EN] && data_s2[8])
    |=> start_seen)
    else $error("Start marker was missed.");

  msg_end_ungated_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (rise && !valid_s2 && ctrl[CTRL_MSG_MODE] && ctrl[CTRL_CAP_EN] &&
     data_s2[9]) |=> end_seen)
    else $error("End marker was gated by valid.");

  raw_upper_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    (sample && !ctrl[CTRL_TEN_BIT]) |=> word[9:8] == 2'b00)
    else $error("Upper bits kept outside ten-bit mode.");

  div_count_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (ctrl[CTRL_CLK_OUT] && $stable(ctrl) && div_cnt == '0 && div == DIV_RESET
     && !psel) |-> ##1 capture_port_clock_out ##2 !capture_port_clock_out)
    else $error("Output clock shape is wrong.");

  pin_edge_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    (!ctrl[CTRL_CLK_OUT] && $past(presetn, 3)) |->
    rise == ($past(capture_port_clock_in, 2) &&
             !$past(capture_port_clock_in, 3)))
    else $error("Input clock edge not seen.");

  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    (sample && rd_data_clr) |=> word_valid ##1 word_valid || rd_data_clr)
    else $error("New word lost to a read clear.");
endmodule // vicp_top
`default_nettype wire

/* sim/vicp_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vicp_src_model (
  output logic clk_pin,
  output logic valid_pin,
  output logic [9:0] data_pin
);
  // The camera clock stands still low between frames.
  initial begin
    clk_pin = 1'b0;
    valid_pin = 1'b0;
    data_pin = 10'h000;
  end
  // One frame: data and valid are set up, one rising edge, then released.
  // Released data lines show the inverse and valid drops low, so a stale word can never pass.
  task automatic send(input logic [9:0] w, input logic v);
    #13;
    data_pin = w;
    valid_pin = v;
    #200 clk_pin = 1'b1;
    #200 clk_pin = 1'b0;
    data_pin = ~w;
    valid_pin = 1'b0;
  endtask
endmodule // vicp_src_model
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vicp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, prev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic clk_out, clk_oe, cam_clk, cam_valid;
  logic [9:0] cam_data;
  int bad_count, check_count, highs, rises;
  vicp_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_port_clock_in(cam_clk), .capture_port_clock_out(clk_out),
    .capture_port_clock_oe(clk_oe), .capture_data_valid(cam_valid),
    .capture_data_lines(cam_data));
  vicp_src_model src_u (.clk_pin(cam_clk), .valid_pin(cam_valid),
    .data_pin(cam_data));
  // Core clock at 20 MHz.
  always #25 pclk = ~pclk;
  // Compares two words and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the wait is bounded so a dead slave cannot hang us.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Samples the output clock on falling edges, clear of its launch edge.
  task automatic measure(input int n);
    highs = 0;
    rises = 0;
    @(negedge pclk);
    prev = clk_out;
    repeat (n) begin
      @(negedge pclk);
      if (clk_out === 1'b1) highs++;
      if (clk_out === 1'b1 && prev === 1'b0) rises++;
      prev = clk_out;
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    bad_count = 0;
    check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0); chk(rd, 32'h0);
    chk({31'h0, clk_oe}, 32'h0);
    apb(1'b0, 12'h010, 32'h0); chk({31'h0, err}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h8); src_u.send(10'h3C3, 1'b1);
    apb(1'b0, ADDR_DATA, 32'h0); chk(rd, 32'h000100C3);
    src_u.send(10'h155, 1'b0);
    apb(1'b0, ADDR_DATA, 32'h0); chk(rd, 32'h000000C3);
    apb(1'b1, ADDR_CTRL, 32'hC); src_u.send(10'h2A5, 1'b1);
    apb(1'b0, ADDR_DATA, 32'h0); chk(rd, 32'h000102A5);
    apb(1'b1, ADDR_CTRL, 32'hA); src_u.send(10'h100, 1'b0);
    apb(1'b0, ADDR_MSG, 32'h0); chk(rd, 32'h1);
    src_u.send(10'h200, 1'b0);
    apb(1'b0, ADDR_MSG, 32'h0); chk(rd, 32'h3);
    apb(1'b0, ADDR_DATA, 32'h0); chk(rd, 32'h000002A5);
    // Two words with no read between: the second stands, overrun is flagged.
    src_u.send(10'h0AB, 1'b1);
    src_u.send(10'h0CD, 1'b1);
    apb(1'b0, ADDR_DATA, 32'h0); chk(rd, 32'h000300CD);
    apb(1'b0, ADDR_DATA, 32'h0); chk(rd, 32'h000000CD);
    apb(1'b1, ADDR_MSG, 32'h3);
    apb(1'b0, ADDR_MSG, 32'h0); chk(rd, 32'h0);
    apb(1'b1, ADDR_DIV, 32'h1);
    apb(1'b0, ADDR_DIV, 32'h0); chk(rd, 32'h2);
    apb(1'b1, ADDR_DIV, 32'h6);
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    chk({31'h0, clk_oe}, 32'h1);
    // Thirteen samples span twelve transitions: two periods of six.
    measure(12);
    chk(highs, 32'd6);
    chk(rises, 32'd2);
    // The reset divisor again, changed while the clock runs: period four.
    apb(1'b1, ADDR_DIV, 32'h4);
    repeat (4) @(posedge pclk);
    measure(8);
    chk(highs, 32'd4);
    chk(rises, 32'd2);
    end_of_test;
  end
  // Watchdog, far beyond the fewer than two hundred cycles the tests need.
  initial begin
    #200000;
    bad_count++;
    end_of_test;
  end
endmodule // tb
`default_nettype wire
